// >>> pkg/sadc_regs.vh
// register map, field positions, reset values and timing counts of the converter control block
`ifndef SADC_REGS_VH
`define SADC_REGS_VH
// ==========================================================
// secondary bus offsets
`define SADC_OFS_PIN_SEL0    8'h2A
`define SADC_OFS_PWR_CTRL    8'h2D
`define SADC_OFS_TIMING_CFG  8'h32
`define SADC_OFS_REF_CFG     8'h42
`define SADC_OFS_PIN_SEL1    8'h53
`define SADC_OFS_PIN_SEL2    8'h54
`define SADC_OFS_PIN_SEL3    8'h55
`define SADC_OFS_PIN_SEL4    8'h56
`define SADC_OFS_PIN_SEL5    8'h57
// ==========================================================
// special function register offsets
`define SADC_SFR_SPT         8'hC1
`define SADC_SFR_SCAN        8'hC3
`define SADC_SFR_CKC         8'hC4
`define SADC_SFR_RES_HI      8'hC5
`define SADC_SFR_RES_LO      8'hC6
`define SADC_SFR_IEN         8'hE6
`define SADC_SFR_IFLAG       8'hF1
`define SADC_SFR_IPRI        8'hF6
// ==========================================================
// field positions and reset values
`define SADC_IRQ_BIT         4
`define SADC_PWR_RST         8'h01
`define SADC_REF_RST         8'h02
`define SADC_INNER_CH        6'h2C
`define SADC_LAST_PIN_CH     6'h2B
// ==========================================================
// timing: fixed tail of a conversion in converter clocks, plus 200 ns
`define SADC_TAIL_CLKS       14
`define SADC_EXTRA_NS        200
`define SADC_CORE_MHZ        40
`endif

// >>> hdl/sadc_ctrl.v
// control logic of the 12-bit successive-approximation converter
//
// Notes on behaviour
// - first pin select: bits 6..0 channels 0..6
// - second pin select: channels 7 to 14
// - third..fifth selects: channels 15..38
// - sixth select: channels 39..43, top reserved
// - power-down bit 0, resets set
// - post-sample interval is three plus field plus sampling delay select
// - bias current bits: set 4uA, clear 5uA
// - bit 5 picks supply or internal reference
// - bit 4 picks 2V or 4V reference
// - bits 3..2 pick internal channel voltage
// - offset cancel timing code, resets to 10
// - conversion time: sample, interval, fourteen, 200ns
// - converter and offset clocks each four choices
// - refuse scan on unselected or reordered channel
// - rising start launches scan, then flag set
// - six-bit channel address, code 44 internal
// - result split high four, low eight
`default_nettype none
`include "sadc_regs.vh"
module sadc_ctrl #(
    parameter integer CH_NUM = 44,
    parameter integer RES_W  = 12
) (
    input  wire              CORE_CLK_I,
    input  wire              RSTN_I,
    input  wire              SFR_WR_I,
    input  wire              SFR_RD_I,
    input  wire [7:0]        SFR_ADDR_I,
    input  wire [7:0]        SFR_WDATA_I,
    input  wire              SEC_WR_I,
    input  wire              SEC_RD_I,
    input  wire [7:0]        SEC_ADDR_I,
    input  wire [7:0]        SEC_WDATA_I,
    input  wire [RES_W-1:0]  AN_RESULT_I,
    output reg  [7:0]        SFR_RDATA_O,
    output reg  [7:0]        SEC_RDATA_O,
    output reg  [CH_NUM-1:0] PIN_ADC_EN_O,
    output reg               CONV_PD_O,
    output reg  [5:0]        CONV_CH_O,
    output reg               SAMPLE_O,
    output reg               CONVERT_O,
    output reg  [1:0]        BIAS_SEL_O,
    output reg               REF_INT_O,
    output reg               REF_4V_O,
    output reg  [1:0]        INNER_V_SEL_O,
    output reg  [1:0]        OC_TIMING_O,
    output reg  [1:0]        CONV_CLK_SEL_O,
    output reg  [1:0]        OC_CLK_SEL_O,
    output reg               FILTER_EN_O,
    output reg               IRQ_FLAG_O,
    output reg               IRQ_EN_O,
    output reg               IRQ_HI_PRI_O
);
// ==========================================================
// configuration registers
reg  [6:0]  pin_sel0_r;
reg  [7:0]  pin_sel1_r, pin_sel2_r, pin_sel3_r, pin_sel4_r;
reg  [4:0]  pin_sel5_r;
reg  [7:0]  pwr_r, timing_r, ref_r;
reg  [7:0]  spt_r, ckc_r, ien_r, iflag_r, ipri_r;
reg  [5:0]  addr_r;
reg         start_r;
reg  [RES_W-1:0] res_r;
// set when pin selection changes after the address was written
reg         order_bad_r;
// ==========================================================
// sequencer, one-hot
localparam [3:0] ST_IDLE = 4'b0001;
localparam [3:0] ST_SAMP = 4'b0010;
localparam [3:0] ST_WAIT = 4'b0100;
localparam [3:0] ST_CONV = 4'b1000;
reg  [3:0]  state_r, state_nxt;
reg  [15:0] cnt_r, cnt_nxt;
reg  [5:0]  div_r;
wire [CH_NUM-1:0] pin_map = {pin_sel5_r, pin_sel4_r, pin_sel3_r,
                             pin_sel2_r, pin_sel1_r, pin_sel0_r};
// the converter clock is derived from the core clock; ticks mark its periods
function [5:0] clk_div;
    input [1:0] sel;
    begin
        case (sel)
            2'b00:   clk_div = 6'd5;
            2'b01:   clk_div = 6'd7;
            2'b10:   clk_div = 6'd10;
            default: clk_div = 6'd13;
        endcase
    end
endfunction
function [3:0] sampling_delay_select_clks;
    input [1:0] sel;
    begin
        case (sel)
            2'b00:   sampling_delay_select_clks = 4'd0;
            2'b01:   sampling_delay_select_clks = 4'd2;
            2'b10:   sampling_delay_select_clks = 4'd4;
            default: sampling_delay_select_clks = 4'd8;
        endcase
    end
endfunction
localparam [15:0] EXTRA_CYC =
    (`SADC_EXTRA_NS * `SADC_CORE_MHZ + 999) / 1000;
localparam [15:0] TAIL_CYC  = `SADC_TAIL_CLKS - 1;
wire tick = (div_r == 6'd0);
wire sec_wr_pin = SEC_WR_I & ((SEC_ADDR_I == `SADC_OFS_PIN_SEL0) |
    ((SEC_ADDR_I >= `SADC_OFS_PIN_SEL1) & (SEC_ADDR_I <= `SADC_OFS_PIN_SEL5)));
wire scan_wr   = SFR_WR_I & (SFR_ADDR_I == `SADC_SFR_SCAN);
wire start_req = scan_wr & SFR_WDATA_I[0] & ~start_r;
wire ch_ok     = (SFR_WDATA_I[6:1] == `SADC_INNER_CH) ||
                 ((SFR_WDATA_I[6:1] <= `SADC_LAST_PIN_CH) &&
                  pin_map[SFR_WDATA_I[6:1]]);
// launch only from idle, powered up, with a legal ordered address
wire launch = start_req & state_r[0] & ~pwr_r[0] & ch_ok &
              ~order_bad_r & ~sec_wr_pin;
wire done = state_r[3] & tick & (cnt_r == 16'd0);
// ==========================================================
// sequencer next state
always @* begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
        ST_IDLE: begin
            if (launch) begin
                state_nxt = ST_SAMP;
                cnt_nxt   = {6'd0, spt_r, 2'b11};
            end
        end
        ST_SAMP: begin
            if (tick) begin
                if (cnt_r == 16'd0) begin
                    state_nxt = ST_WAIT;
                    cnt_nxt   = 16'd2 + {11'd0, timing_r[6:2]} +
                                {12'd0, sampling_delay_select_clks(ckc_r[5:4])};
                end else begin
                    cnt_nxt = cnt_r - 16'd1;
                end
            end
        end
        ST_WAIT: begin
            if (tick) begin
                if (cnt_r == 16'd0) begin
                    state_nxt = ST_CONV;
                    cnt_nxt   = TAIL_CYC;
                end else begin
                    cnt_nxt = cnt_r - 16'd1;
                end
            end
        end
        ST_CONV: begin
            if (tick) begin
                if (cnt_r == 16'd0) begin
                    state_nxt = ST_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 16'd1;
                end
            end
        end
        default: begin
            state_nxt = ST_IDLE;
            cnt_nxt   = 16'd0;
        end
    endcase
    // power-down aborts a scan in flight
    if (pwr_r[0]) begin
        state_nxt = ST_IDLE;
    end
end
// ==========================================================
// sequencer registers and the 200 ns tail, folded into the end
reg [15:0] tail_r;
always @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
        state_r <= ST_IDLE;
        cnt_r   <= 16'h0000;
        div_r   <= 6'd0;
        tail_r  <= 16'h0000;
    end else begin
        state_r <= state_nxt;
        cnt_r   <= cnt_nxt;
        div_r   <= (state_r[0] || tick) ? clk_div(ckc_r[1:0]) : div_r - 6'd1;
        if (done & ~pwr_r[0])
            tail_r <= EXTRA_CYC;
        else if (tail_r != 16'h0000)
            tail_r <= pwr_r[0] ? 16'h0000 : tail_r - 16'd1;
    end
end
wire finish = (tail_r == 16'd1);
// ==========================================================
// register writes
always @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
        pin_sel0_r  <= 7'h00;
        pin_sel1_r  <= 8'h00;
        pin_sel2_r  <= 8'h00;
        pin_sel3_r  <= 8'h00;
        pin_sel4_r  <= 8'h00;
        pin_sel5_r  <= 5'h00;
        pwr_r       <= `SADC_PWR_RST;
        timing_r    <= 8'h00;
        ref_r       <= `SADC_REF_RST;
        spt_r       <= 8'h00;
        ckc_r       <= 8'h00;
        ien_r       <= 8'h00;
        iflag_r     <= 8'h00;
        ipri_r      <= 8'h00;
        addr_r      <= 6'h00;
        start_r     <= 1'b0;
        res_r       <= {RES_W{1'b0}};
        order_bad_r <= 1'b0;
    end else begin
        if (SEC_WR_I) begin
            case (SEC_ADDR_I)
                `SADC_OFS_PIN_SEL0:   pin_sel0_r <= SEC_WDATA_I[6:0];
                `SADC_OFS_PIN_SEL1:   pin_sel1_r <= SEC_WDATA_I;
                `SADC_OFS_PIN_SEL2:   pin_sel2_r <= SEC_WDATA_I;
                `SADC_OFS_PIN_SEL3:   pin_sel3_r <= SEC_WDATA_I;
                `SADC_OFS_PIN_SEL4:   pin_sel4_r <= SEC_WDATA_I;
                `SADC_OFS_PIN_SEL5:   pin_sel5_r <= SEC_WDATA_I[4:0];
                `SADC_OFS_PWR_CTRL:   pwr_r      <= SEC_WDATA_I;
                `SADC_OFS_TIMING_CFG: timing_r   <= {1'b0, SEC_WDATA_I[6:0]};
                `SADC_OFS_REF_CFG:    ref_r      <= {2'b00, SEC_WDATA_I[5:0]};
                default: ;
            endcase
        end
        // a select change after the address stands needs a fresh address write
        if (scan_wr)
            order_bad_r <= 1'b0;
        else if (sec_wr_pin)
            order_bad_r <= 1'b1;
        if (SFR_WR_I) begin
            case (SFR_ADDR_I)
                `SADC_SFR_SPT:  spt_r  <= SFR_WDATA_I;
                `SADC_SFR_CKC:  ckc_r  <= SFR_WDATA_I;
                `SADC_SFR_IEN:  ien_r  <= {SFR_WDATA_I[7:2], 2'b00};
                `SADC_SFR_IPRI: ipri_r <= {SFR_WDATA_I[7:2], 2'b00};
                default: ;
            endcase
        end
        // address writes to the scan register are taken only while the sequencer is idle, the 200 ns tail included
        if (scan_wr && state_r[0])
            addr_r <= SFR_WDATA_I[6:1];
        if (launch)
            start_r <= 1'b1;
        else if (finish || pwr_r[0])
            start_r <= 1'b0;
        if (finish)
            res_r <= AN_RESULT_I;
        // hardware set wins over a software clear in the same cycle
        if (SFR_WR_I && SFR_ADDR_I == `SADC_SFR_IFLAG)
            iflag_r <= {SFR_WDATA_I[7:2], 2'b00};
        if (finish)
            iflag_r[`SADC_IRQ_BIT] <= 1'b1;
    end
end
// ==========================================================
// read data and outputs, all registered
always @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
        SFR_RDATA_O    <= 8'h00;
        SEC_RDATA_O    <= 8'h00;
        PIN_ADC_EN_O   <= {CH_NUM{1'b0}};
        CONV_PD_O      <= 1'b1;
        CONV_CH_O      <= 6'h00;
        SAMPLE_O       <= 1'b0;
        CONVERT_O      <= 1'b0;
        BIAS_SEL_O     <= 2'b00;
        REF_INT_O      <= 1'b0;
        REF_4V_O       <= 1'b0;
        INNER_V_SEL_O  <= 2'b00;
        OC_TIMING_O    <= 2'b10;
        CONV_CLK_SEL_O <= 2'b00;
        OC_CLK_SEL_O   <= 2'b00;
        FILTER_EN_O    <= 1'b0;
        IRQ_FLAG_O     <= 1'b0;
        IRQ_EN_O       <= 1'b0;
        IRQ_HI_PRI_O   <= 1'b0;
    end else begin
        case (SFR_ADDR_I)
            `SADC_SFR_SPT:    SFR_RDATA_O <= spt_r;
            `SADC_SFR_SCAN:   SFR_RDATA_O <= {1'b0, addr_r, start_r};
            `SADC_SFR_CKC:    SFR_RDATA_O <= ckc_r;
            `SADC_SFR_RES_HI: SFR_RDATA_O <= {4'h0, res_r[11:8]};
            `SADC_SFR_RES_LO: SFR_RDATA_O <= res_r[7:0];
            `SADC_SFR_IEN:    SFR_RDATA_O <= ien_r;
            `SADC_SFR_IFLAG:  SFR_RDATA_O <= iflag_r;
            `SADC_SFR_IPRI:   SFR_RDATA_O <= ipri_r;
            default:          SFR_RDATA_O <= 8'h00;
        endcase
        case (SEC_ADDR_I)
            `SADC_OFS_PIN_SEL0:   SEC_RDATA_O <= {1'b0, pin_sel0_r};
            `SADC_OFS_PIN_SEL1:   SEC_RDATA_O <= pin_sel1_r;
            `SADC_OFS_PIN_SEL2:   SEC_RDATA_O <= pin_sel2_r;
            `SADC_OFS_PIN_SEL3:   SEC_RDATA_O <= pin_sel3_r;
            `SADC_OFS_PIN_SEL4:   SEC_RDATA_O <= pin_sel4_r;
            `SADC_OFS_PIN_SEL5:   SEC_RDATA_O <= {3'b000, pin_sel5_r};
            `SADC_OFS_PWR_CTRL:   SEC_RDATA_O <= pwr_r;
            `SADC_OFS_TIMING_CFG: SEC_RDATA_O <= timing_r;
            `SADC_OFS_REF_CFG:    SEC_RDATA_O <= ref_r;
            default:              SEC_RDATA_O <= 8'h00;
        endcase
        PIN_ADC_EN_O   <= pin_map;
        CONV_PD_O      <= pwr_r[0];
        CONV_CH_O      <= addr_r;
        SAMPLE_O       <= state_nxt[1];
        CONVERT_O      <= state_nxt[3];
        BIAS_SEL_O     <= timing_r[1:0];
        REF_INT_O      <= ref_r[5];
        REF_4V_O       <= ref_r[4];
        INNER_V_SEL_O  <= ref_r[3:2];
        OC_TIMING_O    <= ref_r[1:0];
        CONV_CLK_SEL_O <= ckc_r[1:0];
        OC_CLK_SEL_O   <= ckc_r[3:2];
        FILTER_EN_O    <= ckc_r[7];
        IRQ_FLAG_O     <= iflag_r[`SADC_IRQ_BIT];
        IRQ_EN_O       <= ien_r[`SADC_IRQ_BIT];
        IRQ_HI_PRI_O   <= ipri_r[`SADC_IRQ_BIT];
    end
end
endmodule
`default_nettype wire

// >>> verification/sadc_ctrl_assertions.sv
// checker watching the ports of the converter control block
`default_nettype none
module sadc_ctrl_assertions #(
    parameter integer CH_NUM = 44
) (
    input wire logic              CORE_CLK_I,
    input wire logic              RSTN_I,
    input wire logic              SFR_WR_I,
    input wire logic [7:0]        SFR_ADDR_I,
    input wire logic [7:0]        SFR_WDATA_I,
    input wire logic              SEC_WR_I,
    input wire logic [7:0]        SEC_ADDR_I,
    input wire logic [7:0]        SEC_WDATA_I,
    input wire logic [CH_NUM-1:0] PIN_ADC_EN_O,
    input wire logic              CONV_PD_O,
    input wire logic              SAMPLE_O,
    input wire logic              CONVERT_O,
    input wire logic [1:0]        BIAS_SEL_O,
    input wire logic              REF_INT_O,
    input wire logic              REF_4V_O,
    input wire logic [1:0]        INNER_V_SEL_O,
    input wire logic [1:0]        OC_TIMING_O,
    input wire logic              IRQ_FLAG_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RSTN_I);
    // ==========================================================
    // cycles since the converting phase, saturating so it never wraps
    logic [5:0] since_conv_r;
    logic [5:0] since_conv_nxt;
    always_comb since_conv_nxt = CONVERT_O ? 6'h00 :
                                 (since_conv_r == 6'h3F) ? 6'h3F : since_conv_r + 6'h01;
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I)
        if (!RSTN_I) since_conv_r <= 6'h3F;
        else since_conv_r <= since_conv_nxt;
    // ==========================================================
    // register fields reaching the outputs; register then output flop, so two edges
    a_sel_low_map: assert property (
        SEC_WR_I && SEC_ADDR_I == 8'h2A |=> ##1 PIN_ADC_EN_O[6:0] == $past(SEC_WDATA_I[6:0], 2))
        else $error("first pin select not mapped");
    a_sel_second_map: assert property (
        SEC_WR_I && SEC_ADDR_I == 8'h53 |=> ##1 PIN_ADC_EN_O[14:7] == $past(SEC_WDATA_I, 2))
        else $error("second pin select not mapped");
    a_sel_third_map: assert property (
        SEC_WR_I && SEC_ADDR_I == 8'h54 |=> ##1 PIN_ADC_EN_O[22:15] == $past(SEC_WDATA_I, 2))
        else $error("third pin select not mapped");
    a_sel_top_map: assert property (
        SEC_WR_I && SEC_ADDR_I == 8'h57 |=>
        ##1 PIN_ADC_EN_O[43:39] == $past(SEC_WDATA_I[4:0], 2))
        else $error("sixth pin select not mapped");
    a_power_bit_follows: assert property (
        SEC_WR_I && SEC_ADDR_I == 8'h2D |=> ##1 CONV_PD_O == $past(SEC_WDATA_I[0], 2))
        else $error("power-down bit not applied");
    a_bias_sel_follows: assert property (
        SEC_WR_I && SEC_ADDR_I == 8'h32 |=> ##1 BIAS_SEL_O == $past(SEC_WDATA_I[1:0], 2))
        else $error("bias selects not applied");
    a_ref_fields_follow: assert property (
        SEC_WR_I && SEC_ADDR_I == 8'h42 |=>
        ##1 {REF_INT_O, REF_4V_O, INNER_V_SEL_O, OC_TIMING_O} == $past(SEC_WDATA_I[5:0], 2))
        else $error("reference fields not applied");
    // ==========================================================
    // scan sequencing
    a_gap_before_conv: assert property (
        $fell(SAMPLE_O) |-> !CONVERT_O [*8])
        else $error("conversion too soon after sampling");
    a_conv_min_length: assert property (
        $rose(CONVERT_O) |-> CONVERT_O [*8])
        else $error("conversion phase too short");
    a_pd_blocks_scan: assert property (
        CONV_PD_O && $past(CONV_PD_O) |-> !SAMPLE_O && !CONVERT_O)
        else $error("scan activity while powered down");
    a_flag_after_conv: assert property (
        $rose(IRQ_FLAG_O) && !$past(SFR_WR_I && SFR_ADDR_I == 8'hF1 && SFR_WDATA_I[4], 2)
        |-> since_conv_r <= 6'd16)
        else $error("flag raised without a finished conversion");
    a_flag_holds: assert property (
        // the output lags the flag register, so a clear one cycle back still shows high
        IRQ_FLAG_O && !(SFR_WR_I && SFR_ADDR_I == 8'hF1 && !SFR_WDATA_I[4]) &&
        !$past(SFR_WR_I && SFR_ADDR_I == 8'hF1 && !SFR_WDATA_I[4]) |=> IRQ_FLAG_O)
        else $error("flag dropped without software clear");
endmodule
bind sadc_ctrl sadc_ctrl_assertions #(.CH_NUM(CH_NUM)) u_sadc_chk (
    .CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I), .SFR_WR_I(SFR_WR_I), .SFR_ADDR_I(SFR_ADDR_I),
    .SFR_WDATA_I(SFR_WDATA_I), .SEC_WR_I(SEC_WR_I), .SEC_ADDR_I(SEC_ADDR_I),
    .SEC_WDATA_I(SEC_WDATA_I), .PIN_ADC_EN_O(PIN_ADC_EN_O), .CONV_PD_O(CONV_PD_O),
    .SAMPLE_O(SAMPLE_O), .CONVERT_O(CONVERT_O), .BIAS_SEL_O(BIAS_SEL_O), .REF_INT_O(REF_INT_O),
    .REF_4V_O(REF_4V_O), .INNER_V_SEL_O(INNER_V_SEL_O), .OC_TIMING_O(OC_TIMING_O),
    .IRQ_FLAG_O(IRQ_FLAG_O));
`default_nettype wire

// >>> verification/sadc_tb.sv
// self-checking testbench of the converter control block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // stimulus and observed signals
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        sfr_wr = 1'b0, sfr_rd = 1'b0, sec_wr = 1'b0, sec_rd = 1'b0;
    logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sec_addr = 8'h00, sec_wdata = 8'h00;
    logic [11:0] an_result = 12'hA5C;
    logic [7:0]  sfr_rdata, sec_rdata, sel_ofs, cfg;
    logic [43:0] pin_en;
    logic [5:0]  conv_ch;
    logic [1:0]  bias_sel, inner_sel, oc_timing, conv_clk_sel, oc_clk_sel;
    logic        conv_pd, sample, convert, ref_int, ref_4v, irq_flag, irq_en;
    logic        filter_en, irq_hi;
    int          err_count = 0, comparisons = 0, sel_bit;
    logic [7:0]  ofs [9] = '{8'h2A, 8'h2D, 8'h32, 8'h42, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57};
    logic [7:0]  rst_v [9] = '{8'h00, 8'h01, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    always #12.5 clk = ~clk;
    sadc_ctrl DUT (
        .CORE_CLK_I(clk), .RSTN_I(rstn), .SFR_WR_I(sfr_wr), .SFR_RD_I(sfr_rd),
        .SFR_ADDR_I(sfr_addr), .SFR_WDATA_I(sfr_wdata), .SEC_WR_I(sec_wr), .SEC_RD_I(sec_rd),
        .SEC_ADDR_I(sec_addr), .SEC_WDATA_I(sec_wdata), .AN_RESULT_I(an_result),
        .SFR_RDATA_O(sfr_rdata), .SEC_RDATA_O(sec_rdata), .PIN_ADC_EN_O(pin_en),
        .CONV_PD_O(conv_pd), .CONV_CH_O(conv_ch), .SAMPLE_O(sample), .CONVERT_O(convert),
        .BIAS_SEL_O(bias_sel), .REF_INT_O(ref_int), .REF_4V_O(ref_4v),
        .INNER_V_SEL_O(inner_sel), .OC_TIMING_O(oc_timing), .CONV_CLK_SEL_O(conv_clk_sel),
        .OC_CLK_SEL_O(oc_clk_sel), .FILTER_EN_O(filter_en), .IRQ_FLAG_O(irq_flag),
        .IRQ_EN_O(irq_en), .IRQ_HI_PRI_O(irq_hi));
    // ==========================================================
    // access tasks
    task automatic conclude();
        $display("Comparisons: %0d, mismatches: %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // one strobe cycle, then one settling cycle; the address stays put for reads
    task automatic bus(input bit sfr, input bit wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_wr <= sfr & wr;
        sfr_rd <= sfr & !wr;
        sec_wr <= !sfr & wr;
        sec_rd <= !sfr & !wr;
        sfr_addr <= a;
        sec_addr <= a;
        sfr_wdata <= d;
        sec_wdata <= d;
        @(posedge clk);
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b0;
        sec_wr <= 1'b0;
        sec_rd <= 1'b0;
        @(posedge clk);
        @(negedge clk);
    endtask
    task automatic rd(input bit sfr, input logic [7:0] a, input logic [7:0] exp, input string w);
        bus(sfr, 1'b0, a, 8'h00);
        chk(sfr ? sfr_rdata : sec_rdata, exp, w);
    endtask
    // address write, optional reselect in between, then start; refused scans wait 400 cycles
    task automatic scan(input logic [5:0] ch, input bit resel, input bit ok, input int lo,
                        input int hi);
        int n = 0;
        bit seen = 1'b0;
        bus(1, 1, 8'hC3, {1'b0, ch, 1'b0});
        if (resel) bus(0, 1, 8'h2A, 8'h20);
        bus(1, 1, 8'hC3, {1'b0, ch, 1'b1});
        while (irq_flag !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
            seen = seen | (sample === 1'b1) | (convert === 1'b1);
        end
        chk(irq_flag, ok, "scan flag");
        chk(seen, ok, "scan activity");
        if (ok) chk(n >= lo && n <= hi, 1'b1, "scan length");
        bus(1, 1, 8'hF1, 8'h00);
        chk(irq_flag, 1'b0, "flag clear");
    endtask
    // ==========================================================
    // tests
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        chk(conv_pd, 1'b1, "power-down reset");
        chk(oc_timing, 2'b10, "offset timing reset");
        foreach (ofs[i]) rd(0, ofs[i], rst_v[i], "register reset");
        for (int ch = 0; ch < 44; ch++) begin
            sel_ofs = (ch < 7) ? 8'h2A : 8'h53 + 8'((ch - 7) / 8);
            sel_bit = (ch < 7) ? ch : (ch - 7) % 8;
            bus(0, 1, sel_ofs, 8'h01 << sel_bit);
            chk(pin_en, 44'h1 << ch, "pin select map");
            bus(0, 1, sel_ofs, 8'h00);
        end
        bus(0, 1, 8'h2A, 8'hFF);
        bus(0, 1, 8'h57, 8'hFF);
        chk(pin_en, {5'h1F, 32'h0000_0000, 7'h7F}, "unused select bits");
        bus(0, 1, 8'h57, 8'h00);
        bus(0, 1, 8'h32, 8'h0B);
        chk(bias_sel, 2'b11, "bias select set");
        rd(0, 8'h32, 8'h0B, "config readback");
        bus(0, 1, 8'h32, 8'h09);
        chk(bias_sel, 2'b01, "bias select mixed");
        for (int i = 0; i < 4; i++) begin
            cfg = {2'b00, i[0], i[1], i[1:0], i[1:0]};
            bus(0, 1, 8'h42, cfg);
            chk({ref_int, ref_4v, inner_sel, oc_timing}, cfg[5:0], "reference fields");
        end
        bus(0, 1, 8'h42, 8'h02);
        bus(0, 1, 8'h2D, 8'h00);
        chk(conv_pd, 1'b0, "power up");
        bus(1, 1, 8'hC1, 8'h00);
        bus(1, 1, 8'hC4, 8'h00);
        bus(0, 1, 8'h2A, 8'h20);
        bus(1, 1, 8'hE6, 8'h10);
        chk(irq_en, 1'b1, "interrupt enable");
        bus(1, 1, 8'hF6, 8'h10);
        chk(irq_hi, 1'b1, "interrupt priority");
        scan(6'd5, 0, 1, 135, 165);
        chk(conv_ch, 6'd5, "channel address");
        rd(1, 8'hC5, 8'h0A, "result high");
        rd(1, 8'hC6, 8'h5C, "result low");
        rd(1, 8'hC3, 8'h0A, "start cleared");
        scan(6'd6, 0, 0, 0, 0);
        scan(6'd5, 1, 0, 0, 0);
        bus(0, 1, 8'h2D, 8'h01);
        scan(6'd5, 0, 0, 0, 0);
        bus(0, 1, 8'h2D, 8'h00);
        bus(0, 1, 8'h2A, 8'h00);
        @(posedge clk);
        an_result <= 12'h3C1;
        bus(1, 1, 8'hC4, 8'h8F);
        chk({filter_en, oc_clk_sel, conv_clk_sel}, 5'h1F, "clock and filter selects");
        rd(1, 8'hC4, 8'h8F, "clock register readback");
        // internal 2V reference in use, so the slowest converter clock stays selected
        bus(0, 1, 8'h42, 8'h22);
        // filter on: let the input settle for twice a conversion first
        repeat (660) @(posedge clk);
        scan(6'd44, 0, 1, 315, 350);
        rd(1, 8'hC6, 8'hC1, "internal result low");
        rd(1, 8'hC5, 8'h03, "internal result high");
        // the pin reading follows the internal one straight away, pin kept an input
        @(posedge clk);
        an_result <= 12'h7E5;
        bus(0, 1, 8'h2A, 8'h20);
        scan(6'd5, 0, 1, 315, 350);
        rd(1, 8'hC5, 8'h07, "paired pin result high");
        rd(1, 8'hC6, 8'hE5, "paired pin result low");
        conclude();
    end
    // ==========================================================
    // hang guard, well beyond the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        conclude();
    end
endmodule
`default_nettype wire
